//--- common/nfs_pkg.sv
// Constants shared by the sequencer ends: command codes, address layout,
// timing counts and memory sizes.
// Assumes a single 125 MHz system clock on both ends.
package nfs_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam logic [6:0]  CMD_NOP        = 7'h00;
  localparam logic [6:0]  CMD_READ_FUSE  = 7'h07;
  localparam logic [6:0]  CMD_WRITE_LOCK = 7'h08;
  localparam logic [6:0]  CMD_EE_ERASE_ALL  = 7'h30;
  localparam logic [6:0]  CMD_EE_ERASE_PAGE = 7'h32;
  localparam logic [6:0]  CMD_EE_WRITE_PAGE = 7'h34;
  localparam logic [6:0]  CMD_EE_ERASE_WRITE = 7'h35;
  localparam logic [6:0]  CMD_EE_BUF_CLEAR  = 7'h36;
  localparam logic [6:0]  CMD_READ_NVM   = 7'h43;
  localparam int unsigned BYTE_FIELD_TOP_BIT = 4;
  localparam int unsigned PAGE_FIELD_TOP_BIT = 8;
  localparam int unsigned PAGE_BYTES = 1 << (BYTE_FIELD_TOP_BIT + 1);
  localparam int unsigned EE_BYTES   = 1 << (PAGE_FIELD_TOP_BIT + 1);
  localparam int unsigned PAGES      = EE_BYTES / PAGE_BYTES;
  localparam int unsigned FUSE_BYTES = 8;
  localparam logic [23:0] FLASH_BASE   = 24'h800000;
  localparam logic [23:0] EEPROM_BASE  = 24'h8c0000;
  localparam logic [23:0] FUSE_BASE    = 24'h8f0020;
  localparam logic [24:0] DATAMEM_BASE = 25'h1000000;
  localparam logic [7:0]  DBG_RESET_KEY = 8'h59;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [7:0]  LOCK_RESET    = 8'hff;
  localparam logic [1:0]  LOAD_STALL_CYC = 2'd2;
  localparam logic [7:0]  FUSE_CYC   = 8'd4;
  localparam logic [7:0]  LOCK_CYC   = 8'd16;
  localparam logic [7:0]  ERASE_CYC  = 8'd32;
  localparam logic [7:0]  WRITE_CYC  = 8'd32;
  localparam logic [7:0]  BUFCLR_CYC = 8'd2;
endpackage : nfs_pkg

//--- common/nfs_if.sv
// Link between the nonvolatile sequencer and its requesting party.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface nfs_if (
  input wire logic ref_clk_in
);
  logic [6:0]  cmd;
  logic [23:0] addr;
  logic [7:0]  wdata;
  logic        exec;
  logic        unlock;
  logic        external;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        busy;
  logic        cpu_halt;
  logic        port_enabled;
  logic        dbg_reset_wr;
  logic        dbg_key;
  modport dev (input cmd, addr, wdata, exec, unlock, external, mem_rd,
               mem_wr, dbg_reset_wr, dbg_key,
               output rdata, rvalid, busy, cpu_halt, port_enabled);
  modport req (output cmd, addr, wdata, exec, unlock, external, mem_rd,
               mem_wr, dbg_reset_wr, dbg_key,
               input rdata, rvalid, busy, cpu_halt, port_enabled);
endinterface : nfs_if

//--- design/nfs_device.sv
// Nonvolatile sequencer device end: fuse read, lock write, EEPROM page
// buffer and page commands, debug-port enable.
// Assumes the requester holds cmd, addr and wdata stable with each strobe.
`timescale 1ns/1ps
module nfs_device (
  input  wire logic        ref_clk_in,   // System clock.
  input  wire logic        rst_n_in,     // Synchronous reset, active low.
  input  wire logic        clk_en_in,    // Freezes state when low.
  input  wire logic [7:0]  fuse_in [nfs_pkg::FUSE_BYTES], // Fuse values.
  output logic      [7:0]  lock_out,     // Current lock bits.
  output logic             flash_buf_clr_out, // Flash buffer clear pulse.
  nfs_if.dev               bus           // Requester link.
);
  typedef enum logic [5:0] {
    NFS_IDLE  = 6'b000001,
    NFS_FUSE  = 6'b000010,
    NFS_LOCK  = 6'b000100,
    NFS_ERASE = 6'b001000,
    NFS_WRITE = 6'b010000,
    NFS_CLR   = 6'b100000
  } nfs_state_t;

  localparam int unsigned BT = nfs_pkg::BYTE_FIELD_TOP_BIT;
  localparam int unsigned PT = nfs_pkg::PAGE_FIELD_TOP_BIT;

  nfs_state_t  state_q;
  logic [7:0]  cnt_q;
  logic [6:0]  cmd_q;
  logic [PT-BT-1:0] page_q;
  logic [7:0]  fuse_idx_q;
  logic        both_q;
  logic        all_q;
  logic [BT:0] slot_q;
  logic [1:0]  stall_q;
  logic [7:0]  buf_q  [nfs_pkg::PAGE_BYTES];
  logic [nfs_pkg::PAGE_BYTES-1:0] tag_q;
  logic [7:0]  ee_q   [nfs_pkg::EE_BYTES];
  logic [7:0]  lock_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic        busy_q;
  logic        halt_q;
  logic        en_q;
  logic        key_armed_q;
  logic        fclr_q;

  // Protected triggers pass only with unlock or from the debug port.
  wire         idle      = (state_q == NFS_IDLE);
  wire         allowed   = bus.unlock | bus.external;
  wire         exec_go   = bus.exec & idle & allowed;
  wire         cmd_nop   = (bus.cmd == nfs_pkg::CMD_NOP);
  wire         in_ee     = (bus.addr >= nfs_pkg::EEPROM_BASE) &&
                           (bus.addr < nfs_pkg::EEPROM_BASE +
                            24'(nfs_pkg::EE_BYTES));
  wire         in_fuse   = (bus.addr >= nfs_pkg::FUSE_BASE) &&
                           (bus.addr < nfs_pkg::FUSE_BASE +
                            24'(nfs_pkg::FUSE_BYTES));
  wire [PT:0]  ee_off    = bus.addr[PT:0];
  wire [BT:0]  byte_sel  = bus.addr[BT:0];
  wire         load_go   = bus.mem_wr & idle & in_ee &
                           (stall_q == 2'd0);
  wire         read_go   = bus.mem_rd & idle &
                           (bus.cmd == nfs_pkg::CMD_READ_NVM);
  wire [PT:0]  wr_addr   = {page_q, slot_q};
  wire         done      = (cnt_q == 8'd0);
  wire         last_slot = &slot_q;
  wire [7:0]   fuse_val  = fuse_in[fuse_idx_q[2:0]];
  wire [7:0]   ee_rd     = in_fuse ? fuse_in[bus.addr[2:0]] : ee_q[ee_off];

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_q     <= NFS_IDLE;
      cnt_q       <= 8'd0;
      cmd_q       <= nfs_pkg::CMD_NOP;
      page_q      <= '0;
      fuse_idx_q  <= 8'd0;
      both_q      <= 1'b0;
      all_q       <= 1'b0;
      slot_q      <= '0;
      stall_q     <= 2'd0;
      tag_q       <= '0;
      lock_q      <= nfs_pkg::LOCK_RESET;
      rdata_q     <= 8'd0;
      rvalid_q    <= 1'b0;
      busy_q      <= 1'b0;
      halt_q      <= 1'b0;
      en_q        <= 1'b0;
      key_armed_q <= 1'b0;
      fclr_q      <= 1'b0;
    end else if (clk_en_in) begin
      rvalid_q <= 1'b0;
      fclr_q   <= 1'b0;
      if (stall_q != 2'd0) begin
        stall_q <= stall_q - 2'd1;
        halt_q  <= (stall_q != 2'd1);
      end
      // Port enable is sticky once the key follows the reset code.
      if (bus.dbg_reset_wr) begin
        key_armed_q <= 1'b1;
      end
      if (bus.dbg_key && key_armed_q) begin
        en_q <= 1'b1;
      end
      if (load_go) begin
        buf_q[byte_sel] <= bus.wdata;
        tag_q[byte_sel] <= 1'b1;
        stall_q         <= nfs_pkg::LOAD_STALL_CYC;
        halt_q          <= 1'b1;
      end
      if (read_go) begin
        rdata_q  <= ee_rd;
        rvalid_q <= 1'b1;
      end
      case (state_q)
        NFS_IDLE: begin
          if (exec_go && !cmd_nop) begin
            cmd_q  <= bus.cmd;
            page_q <= bus.addr[PT:BT+1];
            slot_q <= '0;
            both_q <= (bus.cmd == nfs_pkg::CMD_EE_ERASE_WRITE);
            all_q  <= (bus.cmd == nfs_pkg::CMD_EE_ERASE_ALL);
            case (bus.cmd)
              nfs_pkg::CMD_READ_FUSE: begin
                state_q    <= NFS_FUSE;
                fuse_idx_q <= bus.addr[7:0];
                cnt_q      <= nfs_pkg::FUSE_CYC;
                busy_q     <= 1'b1;
                halt_q     <= 1'b1;
              end
              nfs_pkg::CMD_WRITE_LOCK: begin
                state_q <= NFS_LOCK;
                cnt_q   <= nfs_pkg::LOCK_CYC;
                busy_q  <= 1'b1;
                halt_q  <= 1'b1;
                lock_q  <= lock_q & bus.wdata;
              end
              nfs_pkg::CMD_EE_ERASE_PAGE, nfs_pkg::CMD_EE_ERASE_WRITE,
              nfs_pkg::CMD_EE_ERASE_ALL: begin
                state_q <= NFS_ERASE;
                cnt_q   <= nfs_pkg::ERASE_CYC;
                busy_q  <= 1'b1;
              end
              nfs_pkg::CMD_EE_WRITE_PAGE: begin
                state_q <= NFS_WRITE;
                cnt_q   <= nfs_pkg::WRITE_CYC;
                busy_q  <= 1'b1;
              end
              nfs_pkg::CMD_EE_BUF_CLEAR: begin
                state_q <= NFS_CLR;
                cnt_q   <= nfs_pkg::BUFCLR_CYC;
                busy_q  <= 1'b1;
              end
              default: begin
                state_q <= NFS_IDLE;
              end
            endcase
          end
        end
        NFS_FUSE: begin
          cnt_q <= cnt_q - 8'd1;
          if (done) begin
            rdata_q  <= fuse_val;
            rvalid_q <= 1'b1;
            busy_q   <= 1'b0;
            halt_q   <= 1'b0;
            state_q  <= NFS_IDLE;
          end
        end
        NFS_LOCK: begin
          cnt_q <= cnt_q - 8'd1;
          if (done) begin
            tag_q   <= '0;
            fclr_q  <= 1'b1;
            busy_q  <= 1'b0;
            halt_q  <= 1'b0;
            state_q <= NFS_IDLE;
          end
        end
        NFS_ERASE: begin
          cnt_q <= cnt_q - 8'd1;
          if (done) begin
            for (int p = 0; p < int'(nfs_pkg::PAGES); p++) begin
              for (int b = 0; b < int'(nfs_pkg::PAGE_BYTES); b++) begin
                if (tag_q[b] && (all_q || p == int'(page_q))) begin
                  ee_q[p*nfs_pkg::PAGE_BYTES+b] <= nfs_pkg::ERASED_BYTE;
                end
              end
            end
            if (both_q) begin
              state_q <= NFS_WRITE;
              cnt_q   <= nfs_pkg::WRITE_CYC;
            end else begin
              busy_q  <= 1'b0;
              state_q <= NFS_IDLE;
            end
          end
        end
        NFS_WRITE: begin
          // Walk one slot per cycle and copy tagged bytes only.
          slot_q <= slot_q + 1'b1;
          if (tag_q[slot_q]) begin
            ee_q[wr_addr] <= buf_q[slot_q];
          end
          cnt_q  <= cnt_q - 8'd1;
          // One pass over the buffer ends the write.
          if (last_slot) begin
            busy_q  <= 1'b0;
            state_q <= NFS_IDLE;
          end
        end
        NFS_CLR: begin
          cnt_q <= cnt_q - 8'd1;
          if (done) begin
            tag_q   <= '0;
            busy_q  <= 1'b0;
            state_q <= NFS_IDLE;
          end
        end
        default: begin
          state_q <= NFS_IDLE;
        end
      endcase
    end
  end

  assign bus.rdata        = rdata_q;
  assign bus.rvalid       = rvalid_q;
  assign bus.busy         = busy_q;
  assign bus.cpu_halt     = halt_q;
  assign bus.port_enabled = en_q;
  assign lock_out         = lock_q;
  assign flash_buf_clr_out = fclr_q;
endmodule : nfs_device

//--- design/nfs_requester.sv
// Requesting end: turns software register writes into sequencer link
// strobes, including the debug-port enable steps.
// Assumes software uses the plain strobe port described on its pins.
`timescale 1ns/1ps
module nfs_requester (
  input  wire logic        ref_clk_in,  // System clock.
  input  wire logic        rst_n_in,    // Synchronous reset, active low.
  input  wire logic        clk_en_in,   // Freezes state when low.
  input  wire logic [3:0]  sw_addr_in,  // Register index.
  input  wire logic [31:0] sw_wdata_in, // Write data.
  input  wire logic        sw_wr_in,    // Write strobe.
  input  wire logic        sw_rd_in,    // Read strobe.
  output logic      [31:0] sw_rdata_out, // Read data, cycle after strobe.
  nfs_if.req               bus          // Device link.
);
  localparam logic [3:0] REG_CMD = 4'h0, REG_ADDR = 4'h1, REG_DATA = 4'h2,
                         REG_CTRL = 4'h3, REG_STAT = 4'h4, REG_MEM = 4'h5;
  logic [6:0]  cmd_q;
  logic [23:0] addr_q;
  logic [7:0]  wdata_q, rd_q;
  logic        ext_q, exec_q, unl_q, mrd_q, mwr_q, rst_q, key_q;
  logic [31:0] rdata_q;
  wire wr_ctrl = sw_wr_in && sw_addr_in == REG_CTRL;
  wire wr_mem  = sw_wr_in && sw_addr_in == REG_MEM;
  wire rd_data = sw_rd_in && sw_addr_in == REG_DATA;
  wire [31:0] stat = {26'd0, bus.port_enabled, bus.cpu_halt, bus.busy,
                      ext_q, 2'd0};
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cmd_q <= nfs_pkg::CMD_NOP; addr_q <= 24'd0; wdata_q <= 8'd0;
      rd_q <= 8'd0; ext_q <= 1'b0; exec_q <= 1'b0; unl_q <= 1'b0;
      mrd_q <= 1'b0; mwr_q <= 1'b0; rst_q <= 1'b0; key_q <= 1'b0;
      rdata_q <= 32'd0;
    end else if (clk_en_in) begin
      // Ctrl bits: 0 exec, 1 unlock, 2 external, 3 reset key, 4 nv key.
      exec_q <= wr_ctrl & sw_wdata_in[0];
      unl_q  <= wr_ctrl & sw_wdata_in[1];
      rst_q  <= wr_ctrl & sw_wdata_in[3] &
                (sw_wdata_in[15:8] == nfs_pkg::DBG_RESET_KEY);
      key_q  <= wr_ctrl & sw_wdata_in[4];
      mwr_q  <= wr_mem;
      mrd_q  <= rd_data;
      if (wr_ctrl) ext_q <= sw_wdata_in[2];
      if (bus.rvalid) rd_q <= bus.rdata;
      // Operands are frozen while the device is busy.
      if (sw_wr_in && !bus.busy) begin
        case (sw_addr_in)
          REG_CMD:  cmd_q   <= sw_wdata_in[6:0];
          REG_ADDR: addr_q  <= sw_wdata_in[23:0];
          REG_DATA, REG_MEM: wdata_q <= sw_wdata_in[7:0];
          default:  cmd_q   <= cmd_q;
        endcase
      end
      case (sw_addr_in)
        REG_CMD:  rdata_q <= {25'd0, cmd_q};
        REG_ADDR: rdata_q <= {8'd0, addr_q};
        REG_DATA: rdata_q <= {24'd0, rd_q};
        REG_STAT: rdata_q <= stat;
        default:  rdata_q <= 32'd0;
      endcase
    end
  end
  assign bus.cmd = cmd_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.exec = exec_q;
  assign bus.unlock = unl_q;
  assign bus.external = ext_q;
  assign bus.mem_rd = mrd_q;
  assign bus.mem_wr = mwr_q;
  assign bus.dbg_reset_wr = rst_q;
  assign bus.dbg_key = key_q;
  assign sw_rdata_out = rdata_q;
endmodule : nfs_requester

//--- sim/nfs_monitor.sv
// Concurrent checks on the sequencer link between requester and device.
// Assumes one clock and a synchronous active-low reset for both ends.
`timescale 1ns/1ps
module nfs_monitor (
  input wire logic       ref_clk_in,      // System clock.
  input wire logic       rst_n_in,        // Synchronous reset, active low.
  input wire logic [6:0] cmd_in,          // Command code.
  input wire logic       exec_in,         // Execute pulse.
  input wire logic       unlock_in,       // Unlock pulse.
  input wire logic       external_in,     // External access level.
  input wire logic       mem_rd_in,       // Memory read pulse.
  input wire logic       mem_wr_in,       // Memory store pulse.
  input wire logic       rvalid_in,       // Read data valid.
  input wire logic       busy_in,         // Device busy.
  input wire logic       cpu_halt_in,     // Processor halted.
  input wire logic       port_enabled_in  // Debug port enabled.
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic take_w = exec_in && (unlock_in || external_in) && !busy_in;
  wire logic ee_w = cmd_in inside {nfs_pkg::CMD_EE_ERASE_ALL,
    nfs_pkg::CMD_EE_ERASE_PAGE, nfs_pkg::CMD_EE_WRITE_PAGE,
    nfs_pkg::CMD_EE_ERASE_WRITE, nfs_pkg::CMD_EE_BUF_CLEAR};
  wire logic act_w = ee_w || cmd_in == nfs_pkg::CMD_READ_FUSE ||
    cmd_in == nfs_pkg::CMD_WRITE_LOCK;

  start_busy_a: assert property (take_w && act_w |=> busy_in)
    else $error("accepted command did not raise busy");
  no_unlock_a: assert property (
    exec_in && !unlock_in && !external_in && !busy_in |=> !busy_in)
    else $error("unprotected trigger started a command");
  nop_idle_a: assert property (
    exec_in && cmd_in == nfs_pkg::CMD_NOP && !busy_in |=> !busy_in)
    else $error("no-operation code raised busy");
  // The fuse byte arrives after the count of four and one closing cycle.
  fuse_data_a: assert property (
    take_w && cmd_in == nfs_pkg::CMD_READ_FUSE |-> ##6 rvalid_in)
    else $error("fuse byte not returned on time");
  ee_nohalt_a: assert property (
    busy_in && ee_w |-> !cpu_halt_in)
    else $error("buffer or page command halted the processor");
  lock_halt_a: assert property (
    busy_in && $past(busy_in) && cmd_in == nfs_pkg::CMD_WRITE_LOCK
    |-> cpu_halt_in)
    else $error("processor running during lock write");
  load_stall_a: assert property (
    mem_wr_in && !busy_in |=> cpu_halt_in [*2] ##1 !cpu_halt_in)
    else $error("buffer load stall is not two cycles");
  busy_end_a: assert property (
    $rose(busy_in) |-> ##[1:80] !busy_in)
    else $error("busy did not clear in time");
  read_block_a: assert property (
    mem_rd_in && busy_in && cmd_in != nfs_pkg::CMD_READ_FUSE
    |=> !rvalid_in)
    else $error("read answered while busy");
  port_keep_a: assert property (
    port_enabled_in |=> port_enabled_in)
    else $error("debug port access dropped");

  cover property (take_w && cmd_in == nfs_pkg::CMD_READ_FUSE);
  cover property (take_w && cmd_in == nfs_pkg::CMD_WRITE_LOCK);
  cover property (take_w && cmd_in == nfs_pkg::CMD_EE_ERASE_WRITE);
  cover property ($rose(port_enabled_in));
endmodule : nfs_monitor

//--- sim/testbench.sv
// Self-checking bench: requester and device joined by the link interface.
// Assumes the requester register map 0 cmd, 1 addr, 2 data, 3 ctrl, 4 stat.
`timescale 1ns/1ps
module testbench;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [3:0]  sw_addr    = 4'h0;
  logic [31:0] sw_wdata   = 32'h0;
  logic        sw_wr      = 1'b0;
  logic        sw_rd      = 1'b0;
  logic [31:0] sw_rdata;
  logic [7:0]  fuse [nfs_pkg::FUSE_BYTES];
  logic [7:0]  lock;
  logic        fclr;
  logic [7:0]  rnd = 8'h39;
  logic [7:0]  exp_lock = nfs_pkg::LOCK_RESET;
  logic [7:0]  v [3];
  logic [4:0]  off [3];
  logic [7:0]  d;
  logic [31:0] s;
  logic [23:0] pa;
  int          num_errors = 0;
  int          n_checks = 0;
  int          n_fclr = 0;
  int          k;

  nfs_if i_nfs_if (.ref_clk_in(ref_clk_in));
  nfs_device i_nfs_device (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .clk_en_in(1'b1), .fuse_in(fuse), .lock_out(lock),
    .flash_buf_clr_out(fclr), .bus(i_nfs_if.dev));
  nfs_requester i_nfs_requester (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .clk_en_in(1'b1), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
    .sw_rdata_out(sw_rdata), .bus(i_nfs_if.req));
  nfs_monitor i_nfs_monitor (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .cmd_in(i_nfs_if.cmd), .exec_in(i_nfs_if.exec),
    .unlock_in(i_nfs_if.unlock), .external_in(i_nfs_if.external),
    .mem_rd_in(i_nfs_if.mem_rd), .mem_wr_in(i_nfs_if.mem_wr),
    .rvalid_in(i_nfs_if.rvalid), .busy_in(i_nfs_if.busy),
    .cpu_halt_in(i_nfs_if.cpu_halt),
    .port_enabled_in(i_nfs_if.port_enabled));

  always #4 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (fclr === 1'b1) n_fclr++;

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  // Lock bits can only move toward the more restrictive (cleared) state.
  function automatic logic [7:0] lock_next(input logic [7:0] o, n);
    return o & n;
  endfunction : lock_next

  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] x);
    @(posedge ref_clk_in);
    sw_addr <= a;
    sw_wdata <= x;
    sw_wr <= 1'b1;
    @(posedge ref_clk_in);
    sw_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] x);
    @(posedge ref_clk_in);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk_in);
    sw_rd <= 1'b0;
    @(negedge ref_clk_in);
    x = sw_rdata;
  endtask : rd

  task automatic run(input logic [6:0] c, input logic [31:0] ctl);
    logic [31:0] st;
    int i;
    wr(4'h0, {25'h0, c});
    wr(4'h3, ctl);
    st = 32'h8;
    for (i = 0; i < 200 && st[3] !== 1'b0; i++) rd(4'h4, st);
    chk("busy", 8'h0, {7'h0, st[3]});
  endtask : run

  task automatic ld(input logic [4:0] o, input logic [7:0] x);
    wr(4'h1, {8'h0, pa | {19'h0, o}});
    wr(4'h5, {24'h0, x});
    repeat (3) @(posedge ref_clk_in);
  endtask : ld

  task automatic ee_rd(input logic [4:0] o, output logic [7:0] x);
    logic [31:0] st;
    wr(4'h0, {25'h0, nfs_pkg::CMD_READ_NVM});
    wr(4'h1, {8'h0, pa | {19'h0, o}});
    rd(4'h2, st);
    repeat (8) @(posedge ref_clk_in);
    rd(4'h2, st);
    x = st[7:0];
  endtask : ee_rd

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (30000) @(posedge ref_clk_in);
    num_errors++;
    give_verdict();
  end

  initial begin
    for (k = 0; k < nfs_pkg::FUSE_BYTES; k++) begin
      rnd = lfsr(rnd);
      fuse[k] = rnd;
    end
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    for (k = 0; k < nfs_pkg::FUSE_BYTES; k++) begin
      wr(4'h1, k);
      run(nfs_pkg::CMD_READ_FUSE, 32'h3);
      rd(4'h2, s);
      chk("fuse byte", fuse[k], s[7:0]);
    end
    // Second try lacks the unlock; third comes from the debug port.
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      wr(4'h2, {24'h0, rnd});
      run(nfs_pkg::CMD_WRITE_LOCK, k == 1 ? 32'h1 : (k == 2 ? 32'h5 : 32'h3));
      if (k != 1) exp_lock = lock_next(exp_lock, rnd);
      chk("lock bits", exp_lock, lock);
    end
    chk("flash clear count", 8'd2, n_fclr[7:0]);
    run(nfs_pkg::CMD_NOP, 32'h3);
    chk("lock after nop", exp_lock, lock);
    rnd = lfsr(rnd);
    pa = nfs_pkg::EEPROM_BASE | {15'h0, rnd[3:0], 5'h0};
    off = '{5'd0, 5'd31, {1'b0, rnd[7:5], 1'b1}};
    run(nfs_pkg::CMD_EE_BUF_CLEAR, 32'h3);
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      v[k] = rnd;
      ld(off[k], v[k]);
    end
    run(nfs_pkg::CMD_EE_ERASE_WRITE, 32'h3);
    for (k = 0; k < 3; k++) begin
      ee_rd(off[k], d);
      chk("eeprom page byte", v[k], d);
    end
    ld(5'd0, ~v[0]);
    wr(4'h2, 32'hff);
    run(nfs_pkg::CMD_WRITE_LOCK, 32'h3);
    run(nfs_pkg::CMD_EE_ERASE_WRITE, 32'h3);
    ee_rd(5'd0, d);
    chk("byte after lock clear", v[0], d);
    run(nfs_pkg::CMD_EE_BUF_CLEAR, 32'h3);
    ld(5'd0, 8'h5a);
    run(nfs_pkg::CMD_EE_ERASE_PAGE, 32'h3);
    ee_rd(5'd0, d);
    chk("erased tagged byte", nfs_pkg::ERASED_BYTE, d);
    ee_rd(5'd31, d);
    chk("untagged byte kept", v[1], d);
    run(nfs_pkg::CMD_EE_BUF_CLEAR, 32'h3);
    ld(5'd0, v[2]);
    run(nfs_pkg::CMD_EE_WRITE_PAGE, 32'h3);
    ee_rd(5'd0, d);
    chk("written tagged byte", v[2], d);
    run(nfs_pkg::CMD_EE_BUF_CLEAR, 32'h3);
    pa = pa ^ 24'h20;
    ld(5'd31, 8'h00);
    pa = pa ^ 24'h20;
    // A code written while busy must not replace the running one.
    wr(4'h0, {25'h0, nfs_pkg::CMD_EE_ERASE_ALL});
    wr(4'h3, 32'h3);
    wr(4'h0, {25'h0, nfs_pkg::CMD_READ_FUSE});
    rd(4'h0, s);
    chk("cmd held", {1'b0, nfs_pkg::CMD_EE_ERASE_ALL}, s[7:0]);
    run(nfs_pkg::CMD_EE_ERASE_ALL, 32'h0);
    ee_rd(5'd31, d);
    chk("erase all tagged", nfs_pkg::ERASED_BYTE, d);
    ee_rd(off[2], d);
    chk("erase all untagged", v[2], d);
    wr(4'h3, {16'h0, nfs_pkg::DBG_RESET_KEY, 8'h08});
    wr(4'h3, 32'h10);
    s = 32'h0;
    for (k = 0; k < 50 && s[5] !== 1'b1; k++) rd(4'h4, s);
    chk("port enabled", 8'h1, {7'h0, s[5]});
    repeat (20) @(posedge ref_clk_in);
    rd(4'h4, s);
    chk("port stays enabled", 8'h1, {7'h0, s[5]});
    give_verdict();
  end
endmodule : testbench
